/* core/frc_host.v */
`timescale 1ns/1ps
`include "frc_defines.vh"
// host controller driving the fifo's write and read ports and straps
module frc_host #(
    parameter DW    = 18,   // data width
    parameter LARGE = 0     // 1 for the larger depth variant
) (
    // clock and reset
    input  wire          SYS_CLK_IN,
    input  wire          ARST_N_IN,
    // software port
    input  wire [3:0]    ADDR_IN,
    input  wire [31:0]   WDATA_IN,
    input  wire          WR_IN,
    input  wire          RD_IN,
    output reg  [31:0]   RDATA_OUT,
    // device straps and resets
    output reg           MASTER_RESET_N_OUT,
    output reg           PARTIAL_RESET_N_OUT,
    output reg           FALL_THROUGH_TIMING_OUT,
    output reg           RETRANSMIT_TIMING_SELECT_OUT,
    output reg           FLAG_TIMING_SELECT_OUT,
    // device write port
    output reg           WEN_N_OUT,
    output reg  [DW-1:0] DATA_OUT,
    output reg           OFFSET_LOAD_N_OUT,
    output reg           SEN_N_OUT,
    output reg           SDATA_OUT,
    // device read port
    output reg           REN_N_OUT,
    output reg           RETX_N_OUT,
    output reg           OE_N_OUT,
    input  wire [DW-1:0] Q_IN,
    // device flags, all active low
    input  wire          EMPTY_FLAG_N_IN,   // word present when fall_through_timing
    input  wire          FULL_FLAG_N_IN,    // input ready when fall_through_timing
    input  wire          ALMOST_EMPTY_FLAG_N_IN,
    input  wire          ALMOST_FULL_FLAG_N_IN,
    input  wire          HALF_FULL_FLAG_N_IN
);
    // states
    localparam S_IDLE  = 3'h0;
    localparam S_RST   = 3'h1;
    localparam S_RETX  = 3'h2;
    localparam S_WAIT  = 3'h3;
    localparam S_LOAD  = 3'h4;

    reg  [2:0]    st_q;       // controller state
    reg  [7:0]    ctrl_q;     // mode control
    reg  [DW-1:0] wdat_q;     // word to write
    reg  [DW-1:0] rdat_q;     // last word read
    reg  [31:0]   wcnt_q;     // writes since reset
    reg  [31:0]   rcnt_q;     // reads since reset or retransmit
    reg  [18:0]   ae_q;       // almost-empty offset
    reg  [18:0]   af_q;       // almost-full offset
    reg  [3:0]    tmr_q;      // reset pulse timer
    reg  [2:0]    rdp_q;      // read strobe age, one bit per cycle
    reg           err_q;      // refused command, sticky
    reg           ld_go_q;    // start serial load
    wire [4:0]    flg_s;      // synchronised flags
    wire [DW-1:0] q_s;        // synchronised read data
    wire          ser_en;
    wire          ser_dat;
    wire          ser_busy;

    // flag word: empty, full, almost empty, almost full, half full
    frc_sync2 #(.W(5)) u_flg (
        .clk_in    (SYS_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .d_in      ({EMPTY_FLAG_N_IN, FULL_FLAG_N_IN,
                     ALMOST_EMPTY_FLAG_N_IN, ALMOST_FULL_FLAG_N_IN,
                     HALF_FULL_FLAG_N_IN}),
        .q_out     (flg_s)
    );
    // read data also crosses from the device pins
    frc_sync2 #(.W(DW)) u_q (
        .clk_in    (SYS_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .d_in      (Q_IN),
        .q_out     (q_s)
    );
    // serial offset loader
    frc_offset_ser u_ser (
        .clk_in    (SYS_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .start_in  (ld_go_q),
        .top_in    (ser_top(ctrl_q[`FRC_CTRL_X9X9])),
        .ae_in     (ae_q),
        .af_in     (af_q),
        .sen_out   (ser_en),
        .sdat_out  (ser_dat),
        .busy_out  (ser_busy)
    );

    wire fall_through_timing  = ctrl_q[`FRC_CTRL_FALL_THROUGH_TIMING];
    wire f_emp = flg_s[4];   // empty flag, or word-present in fall_through_timing
    wire f_ful = flg_s[3];   // full flag, or input-ready in fall_through_timing

    // top serial bit index per width mode and variant
    function [4:0] ser_top;
        input x9;
        begin
            if (x9)
                ser_top = LARGE ? `FRC_SER_X9X9_LG : `FRC_SER_X9X9_SM;
            else
                ser_top = LARGE ? `FRC_SER_OTHER_LG : `FRC_SER_OTHER_SM;
        end
    endfunction

    // depth for current mode, fall-through one larger
    function [31:0] depth;
        input ft;
        input x9;
        reg [31:0] b;
        begin
            b = x9 ? `FRC_DEPTH_X9X9 : `FRC_DEPTH_STD;
            if (LARGE)
                b = {b[30:0], 1'b0};
            depth = ft ? b + 32'd1 : b;
        end
    endfunction

    // device may take data: standard full high, fall_through_timing input-ready low
    wire can_wr = fall_through_timing ? !f_ful : f_ful;
    // device has data: standard empty high, fall_through_timing word-present low
    wire can_rd = fall_through_timing ? !f_emp : f_emp;
    // write limit before retransmit setup
    wire wr_lim = wcnt_q >= depth(fall_through_timing, ctrl_q[`FRC_CTRL_X9X9]) - 32'd2;
    // retransmit preconditions
    wire retx_ok = (wcnt_q >= `FRC_MIN_WR) &&
                   (fall_through_timing || rcnt_q >= `FRC_MIN_RD);
    wire cmd = WR_IN && ADDR_IN == `FRC_REG_CMD;

    // main sequencer and pin drivers
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_q    <= S_IDLE;
            ctrl_q  <= `FRC_CTRL_RST;
            wdat_q  <= {DW{1'b0}};
            rdat_q  <= {DW{1'b0}};
            wcnt_q  <= 32'h0;
            rcnt_q  <= 32'h0;
            ae_q    <= 19'h0007f;
            af_q    <= 19'h0007f;
            tmr_q   <= 4'h0;
            rdp_q   <= 3'h0;
            err_q   <= 1'b0;
            ld_go_q <= 1'b0;
            MASTER_RESET_N_OUT           <= 1'b1;
            PARTIAL_RESET_N_OUT          <= 1'b1;
            FALL_THROUGH_TIMING_OUT      <= 1'b0;
            RETRANSMIT_TIMING_SELECT_OUT <= 1'b1;
            FLAG_TIMING_SELECT_OUT       <= 1'b1;
            WEN_N_OUT         <= 1'b1;
            DATA_OUT          <= {DW{1'b0}};
            OFFSET_LOAD_N_OUT <= 1'b1;
            SEN_N_OUT         <= 1'b1;
            SDATA_OUT         <= 1'b0;
            REN_N_OUT         <= 1'b1;
            RETX_N_OUT        <= 1'b1;
            OE_N_OUT          <= 1'b0;
        end else begin
            // strobes default to idle each cycle
            WEN_N_OUT  <= 1'b1;
            REN_N_OUT  <= 1'b1;
            RETX_N_OUT <= 1'b1;
            ld_go_q    <= 1'b0;
            SEN_N_OUT  <= !ser_en;
            SDATA_OUT  <= ser_dat;
            // standard data lands an edge after the strobe, then two
            // sync stages; fall-through shows the head word beforehand
            rdp_q <= {rdp_q[1:0], !REN_N_OUT};
            if (FALL_THROUGH_TIMING_OUT ? rdp_q[0] : rdp_q[2])
                rdat_q <= q_s;
            // software register writes
            if (WR_IN && ADDR_IN == `FRC_REG_CTRL)
                ctrl_q <= WDATA_IN[7:0];
            if (WR_IN && ADDR_IN == `FRC_REG_WDATA)
                wdat_q <= WDATA_IN[DW-1:0];
            if (WR_IN && ADDR_IN == `FRC_REG_OFFSET) begin
                ae_q <= {3'h0, WDATA_IN[15:0]};
                af_q <= {3'h0, WDATA_IN[31:16]};
            end
            // error flag: write-one to clear, new error wins
            if (WR_IN && ADDR_IN == `FRC_REG_STATUS && WDATA_IN[8])
                err_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (cmd && (WDATA_IN[`FRC_CMD_MRS] ||
                                WDATA_IN[`FRC_CMD_PRS])) begin
                        // straps held through master reset
                        // flag timing strap
                        MASTER_RESET_N_OUT  <= !WDATA_IN[`FRC_CMD_MRS];
                        PARTIAL_RESET_N_OUT <= WDATA_IN[`FRC_CMD_MRS];
                        FALL_THROUGH_TIMING_OUT <= fall_through_timing;
                        RETRANSMIT_TIMING_SELECT_OUT <=
                            ctrl_q[`FRC_CTRL_RMNORM];
                        FLAG_TIMING_SELECT_OUT <=
                            ctrl_q[`FRC_CTRL_SYNCFLG];
                        // output enable driven low in both timing modes
                        OE_N_OUT <= 1'b0;
                        tmr_q    <= `FRC_RST_CYC;
                        wcnt_q   <= 32'h0;
                        rcnt_q   <= 32'h0;
                        st_q     <= S_RST;
                    end else if (cmd && WDATA_IN[`FRC_CMD_WRITE]) begin
                        if (can_wr && !wr_lim) begin
                            WEN_N_OUT <= 1'b0;
                            DATA_OUT  <= wdat_q;
                            wcnt_q    <= wcnt_q + 32'h1;
                        end else
                            err_q <= 1'b1;
                    end else if (cmd && WDATA_IN[`FRC_CMD_READ]) begin
                        // read gated by ready flag
                        if (can_rd) begin
                            REN_N_OUT <= 1'b0;
                            rcnt_q    <= rcnt_q + 32'h1;
                        end else
                            err_q <= 1'b1;
                    end else if (cmd && WDATA_IN[`FRC_CMD_RETX]) begin
                        // replays from first word after reset
                        if (retx_ok) begin
                            RETX_N_OUT <= 1'b0;
                            st_q <= S_RETX;
                        end else
                            err_q <= 1'b1;
                    end else if (cmd && WDATA_IN[`FRC_CMD_LOAD]) begin
                        OFFSET_LOAD_N_OUT <= 1'b0;
                        ld_go_q <= 1'b1;
                        st_q    <= S_LOAD;
                    end
                end
                S_RST: begin
                    // hold reset pulse, then release
                    tmr_q <= tmr_q - 4'h1;
                    if (tmr_q == 4'h1) begin
                        MASTER_RESET_N_OUT  <= 1'b1;
                        PARTIAL_RESET_N_OUT <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                S_RETX: begin
                    // give synced flags time to show setup start
                    tmr_q <= `FRC_RST_CYC;
                    st_q  <= S_WAIT;
                end
                S_WAIT: begin
                    // zero-latency: flag updates at once
                    // normal: wait for setup done
                    if (tmr_q != 4'h0)
                        tmr_q <= tmr_q - 4'h1;
                    else if (!RETRANSMIT_TIMING_SELECT_OUT || can_rd) begin
                        rcnt_q <= 32'h0;
                        st_q   <= S_IDLE;
                    end
                end
                S_LOAD: begin
                    // serial load keeps load low until done
                    // wait for the last serial bit to leave the pins
                    if (!ld_go_q && !ser_busy && !ser_en) begin
                        OFFSET_LOAD_N_OUT <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // read data register, one cycle after the read strobe
    // flags reported raw: sync/async timing is the device's
    // parallel offset load not used here; serial top bit index depends on x9 mode
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RDATA_OUT <= 32'h0;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `FRC_REG_CTRL:   RDATA_OUT <= {24'h0, ctrl_q};
                `FRC_REG_STATUS: RDATA_OUT <= {22'h0, st_q == S_IDLE,
                                  err_q, st_q, flg_s};
                `FRC_REG_WDATA:  RDATA_OUT <= {{(32-DW){1'b0}}, wdat_q};
                `FRC_REG_RDATA:  RDATA_OUT <= {{(32-DW){1'b0}}, rdat_q};
                `FRC_REG_WCOUNT: RDATA_OUT <= wcnt_q;
                `FRC_REG_RCOUNT: RDATA_OUT <= rcnt_q;
                `FRC_REG_OFFSET: RDATA_OUT <= {af_q[15:0], ae_q[15:0]};
                default:         RDATA_OUT <= 32'h0;
            endcase
        end else begin
            RDATA_OUT <= 32'h0;
        end
    end
endmodule // frc_host

/* core/frc_defines.vh */
// Functional notes
// - standard normal retransmit: read only after empty_flag_n high
// - standard mode: write at most D-2 before retransmit
// - fall-through mode: at most D-2, D one larger
// - standard retransmit needs two writes and two reads
// - fall-through retransmit needs only two writes
// - retransmit select high at reset: normal, low: zero-latency
// - serial offset load top bit index per width mode
// - x9 parallel offset load/read takes one extra cycle each; the host uses serial offset load only
// - flag timing select high at reset: synchronous flags
// - flag timing select low at reset: asynchronous flags
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH
// software register offsets (word addresses)
`define FRC_REG_CTRL      4'h0
`define FRC_REG_STATUS    4'h1
`define FRC_REG_WDATA     4'h2
`define FRC_REG_RDATA     4'h3
`define FRC_REG_WCOUNT    4'h4
`define FRC_REG_RCOUNT    4'h5
`define FRC_REG_OFFSET    4'h6
`define FRC_REG_CMD       4'h7
// control field positions
`define FRC_CTRL_FALL_THROUGH_TIMING     0
`define FRC_CTRL_RMNORM   1
`define FRC_CTRL_SYNCFLG  2
`define FRC_CTRL_X9X9     3
`define FRC_CTRL_BIG      4
`define FRC_CTRL_RST      8'h1f
// command field positions
`define FRC_CMD_MRS       0
`define FRC_CMD_PRS       1
`define FRC_CMD_WRITE     2
`define FRC_CMD_READ      3
`define FRC_CMD_RETX      4
`define FRC_CMD_LOAD      5
// depths, small variant
`define FRC_DEPTH_STD     32'd131072
`define FRC_DEPTH_X9X9    32'd262144
// serial top bit index, small/large variant
`define FRC_SER_X9X9_SM   5'd17
`define FRC_SER_X9X9_LG   5'd18
`define FRC_SER_OTHER_SM  5'd16
`define FRC_SER_OTHER_LG  5'd17
// minimum counts before retransmit
`define FRC_MIN_WR        32'd2
`define FRC_MIN_RD        32'd2
// reset pulse length in cycles
`define FRC_RST_CYC       4'h4
`endif

/* core/frc_sync2.v */
`timescale 1ns/1ps
// two flip-flop synchroniser for a group of device pins, flags or read data
module frc_sync2 #(
    parameter W = 6
) (
    input  wire         clk_in,
    input  wire         arst_n_in,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] m_q;  // first stage, read only by second
    reg [W-1:0] s_q;  // second stage

    // flags idle high after reset
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            m_q <= {W{1'b1}};
            s_q <= {W{1'b1}};
        end else begin
            m_q <= d_in;
            s_q <= m_q;
        end
    end
    assign q_out = s_q;
endmodule // frc_sync2

/* core/frc_offset_ser.v */
`timescale 1ns/1ps
// shifts the two offsets out serially, lsb first, empty then full
module frc_offset_ser (
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire        start_in,   // one-cycle pulse
    input  wire [4:0]  top_in,     // highest bit index per offset
    input  wire [18:0] ae_in,      // almost-empty offset
    input  wire [18:0] af_in,      // almost-full offset
    output reg         sen_out,    // serial enable
    output reg         sdat_out,   // serial data
    output reg         busy_out
);
    reg [5:0] cnt_q;   // bit counter over both offsets
    reg [5:0] last_q;  // final bit index
    wire [5:0] half = {1'b0, top_in} + 6'h01;

    // walk both offsets, one bit per cycle
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q    <= 6'h00;
            last_q   <= 6'h00;
            sen_out  <= 1'b0;
            sdat_out <= 1'b0;
            busy_out <= 1'b0;
        end else if (start_in && !busy_out) begin
            cnt_q    <= 6'h00;
            last_q   <= {half[4:0], 1'b0} - 6'h01;
            busy_out <= 1'b1;
            sen_out  <= 1'b0;
        end else if (busy_out) begin
            sen_out  <= 1'b1;
            // first half empty offset, second half full offset
            sdat_out <= (cnt_q < half) ? ae_in[cnt_q[4:0]]
                                       : af_in[cnt_q[4:0] - half[4:0]];
            cnt_q    <= cnt_q + 6'h01;
            if (cnt_q == last_q)
                busy_out <= 1'b0;
        end else begin
            sen_out  <= 1'b0;
        end
    end
endmodule // frc_offset_ser

/* tb/frc_host_asserts.sv */
`timescale 1ns/1ps
// checks the host's device strobes against the software orders behind them
module frc_host_asserts (
    // clock and reset
    input wire        SYS_CLK_IN,
    input wire        ARST_N_IN,
    // software port
    input wire [3:0]  ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire        WR_IN,
    input wire        RD_IN,
    input wire [31:0] RDATA_OUT,
    // device side
    input wire        MASTER_RESET_N_OUT,
    input wire        FALL_THROUGH_TIMING_OUT,
    input wire        RETRANSMIT_TIMING_SELECT_OUT,
    input wire        FLAG_TIMING_SELECT_OUT,
    input wire        WEN_N_OUT,
    input wire        REN_N_OUT,
    input wire        RETX_N_OUT,
    input wire        OFFSET_LOAD_N_OUT,
    input wire        SEN_N_OUT,
    input wire        EMPTY_FLAG_N_IN
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    reg  [31:0] wr_q;   // device writes since the last master reset
    reg  [31:0] rd_q;   // device reads, kept since reset: a looser bound
    wire        cmd_w = WR_IN && (ADDR_IN == 4'h7);   // command write
    // strobe counters; a master reset pulse restarts both
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wr_q <= 32'h0;
            rd_q <= 32'h0;
        end else if (!MASTER_RESET_N_OUT) begin
            wr_q <= 32'h0;
            rd_q <= 32'h0;
        end else begin
            wr_q <= wr_q + {31'h0, ~WEN_N_OUT};
            rd_q <= rd_q + {31'h0, ~REN_N_OUT};
        end
    end
    wen_cause_a: assert property ($fell(WEN_N_OUT) |->
        $past(cmd_w && WDATA_IN[2])) else $error("write strobe uncommanded");
    wen_pulse_a: assert property ($fell(WEN_N_OUT) |=> WEN_N_OUT)
        else $error("write strobe too long");
    ren_cause_a: assert property ($fell(REN_N_OUT) |->
        $past(cmd_w && WDATA_IN[3])) else $error("read strobe uncommanded");
    read_ready_a: assert property ($fell(REN_N_OUT) |->
        $past(EMPTY_FLAG_N_IN, 3) != FALL_THROUGH_TIMING_OUT)
        else $error("read with no word ready");
    retx_writes_a: assert property ($fell(RETX_N_OUT) |->
        wr_q >= 32'h2) else $error("retransmit before two writes");
    retx_reads_a: assert property ($fell(RETX_N_OUT) &&
        !FALL_THROUGH_TIMING_OUT |-> rd_q >= 32'h2)
        else $error("retransmit before two reads");
    retx_pulse_a: assert property ($fell(RETX_N_OUT) |=> RETX_N_OUT)
        else $error("retransmit strobe too long");
    mrs_len_a: assert property ($fell(MASTER_RESET_N_OUT) |->
        !MASTER_RESET_N_OUT [*4] ##1 MASTER_RESET_N_OUT)
        else $error("master reset pulse not four cycles");
    strap_hold_a: assert property (!MASTER_RESET_N_OUT &&
        $past(!MASTER_RESET_N_OUT) |-> $stable({FALL_THROUGH_TIMING_OUT,
        RETRANSMIT_TIMING_SELECT_OUT, FLAG_TIMING_SELECT_OUT}))
        else $error("strap moved during master reset");
    sen_in_load_a: assert property (!SEN_N_OUT |-> !OFFSET_LOAD_N_OUT)
        else $error("serial enable outside load");
    rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside answer cycle");
    cover property ($fell(RETX_N_OUT));
    cover property ($rose(OFFSET_LOAD_N_OUT));
    cover property ($fell(REN_N_OUT) && FALL_THROUGH_TIMING_OUT);
endmodule // frc_host_asserts

bind frc_host frc_host_asserts u_chk (.SYS_CLK_IN(SYS_CLK_IN),
    .ARST_N_IN(ARST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .MASTER_RESET_N_OUT(MASTER_RESET_N_OUT),
    .FALL_THROUGH_TIMING_OUT(FALL_THROUGH_TIMING_OUT),
    .RETRANSMIT_TIMING_SELECT_OUT(RETRANSMIT_TIMING_SELECT_OUT),
    .FLAG_TIMING_SELECT_OUT(FLAG_TIMING_SELECT_OUT),
    .WEN_N_OUT(WEN_N_OUT), .REN_N_OUT(REN_N_OUT), .RETX_N_OUT(RETX_N_OUT),
    .OFFSET_LOAD_N_OUT(OFFSET_LOAD_N_OUT), .SEN_N_OUT(SEN_N_OUT),
    .EMPTY_FLAG_N_IN(EMPTY_FLAG_N_IN));

/* tb/frc_dev_model.sv */
`timescale 1ns/1ps
// shallow behavioural fifo; both device clocks are the system clock here
module frc_dev_model #(
    parameter AE_N = 7   // almost-empty offset, plain default
) (
    // clock, resets, straps
    input  wire        clk_in,
    input  wire        mrs_n_in,
    input  wire        prs_n_in,
    input  wire        ft_in,
    input  wire        rm_in,
    // ports
    input  wire        wen_n_in,
    input  wire [17:0] d_in,
    input  wire        ld_n_in,
    input  wire        sen_n_in,
    input  wire        sdat_in,
    input  wire        ren_n_in,
    input  wire        retx_n_in,
    input  wire        oe_n_in,
    output wire [17:0] q_out,
    // flags
    output wire        ef_n_out,
    output wire        pae_n_out
);
    reg  [17:0] mem_q [0:63];   // only 64 words: tests stay shallow
    reg  [5:0]  wp_q = 6'h0;    // write pointer
    reg  [5:0]  rp_q = 6'h0;    // read pointer
    reg  [17:0] q_q = 18'h0;    // registered output word
    reg         ft_q = 1'b0;    // latched timing strap
    reg         rm_q = 1'b1;    // latched retransmit strap
    reg  [2:0]  setup_q = 3'h0; // retransmit setup countdown
    reg  [6:0]  nb_q = 7'h0;    // serial offset bits taken
    reg         ld_q = 1'b1;    // load pin one edge ago
    reg         bits_q [0:63];  // serial offset bits in arrival order
    wire [5:0]  cnt = wp_q - rp_q;
    wire        present = (cnt != 6'h0) && (setup_q == 3'h0);
    wire [17:0] q = ft_q ? mem_q[rp_q] : q_q;
    // fall-through shows the head word; released bus shows the inverse
    assign q_out = oe_n_in ? ~q : q;
    assign ef_n_out = ft_q ? !present : present;
    assign pae_n_out = cnt > (ft_q ? AE_N + 1 : AE_N);
    // straps, pointers, retransmit and serial load
    always @(posedge clk_in) begin
        if (!mrs_n_in) begin
            ft_q <= ft_in;
            rm_q <= rm_in;
        end
        if (!mrs_n_in || !prs_n_in) begin
            wp_q <= 6'h0;
            rp_q <= 6'h0;
            setup_q <= 3'h0;
        end else begin
            if (!wen_n_in) begin
                mem_q[wp_q] <= d_in;
                wp_q <= wp_q + 6'h1;
            end
            if (!retx_n_in) begin
                rp_q <= 6'h0;
                setup_q <= rm_q ? 3'h3 : 3'h0;
            end else if (!ren_n_in) begin
                q_q <= mem_q[rp_q];
                rp_q <= rp_q + 6'h1;
            end else if (setup_q != 3'h0) begin
                setup_q <= setup_q - 3'h1;
            end
        end
        ld_q <= ld_n_in;
        // count restarts as load opens and survives its close
        if (!ld_n_in && ld_q) begin
            nb_q <= 7'h0;
        end else if (!ld_n_in && !sen_n_in) begin
            bits_q[nb_q[5:0]] <= sdat_in;
            nb_q <= nb_q + 7'h1;
        end
    end
endmodule // frc_dev_model

/* tb/frc_host_tb_top.sv */
`timescale 1ns/1ps
// drives the software port, scores read answers from a queue
module frc_host_tb_top;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [3:0]  addr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         rd_d = 1'b0;      // read answer due this edge
    wire [31:0] rdata;
    wire [17:0] dq;
    wire [17:0] q;
    wire        mrs_n, prs_n, ft, rm, flag_timing_select, wen_n, ld_n, sen_n, sdat;
    wire        ren_n, retx_n, oe_n, ef_n, pae_n;
    integer     num_errors = 0;
    integer     n_tests = 0;
    integer     seed = 65;
    integer     cyc = 0;
    integer     i, m, x;
    reg  [31:0] exp_q [$];        // expected answers, oldest first
    reg  [31:0] msk_q [$];        // bits that matter in each answer
    reg  [31:0] offs, got;
    reg  [17:0] w [0:2];
    always #50 clk = ~clk;
    frc_host #(.DW(18), .LARGE(0)) u_dut (.SYS_CLK_IN(clk),
        .ARST_N_IN(arst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .MASTER_RESET_N_OUT(mrs_n),
        .PARTIAL_RESET_N_OUT(prs_n), .FALL_THROUGH_TIMING_OUT(ft),
        .RETRANSMIT_TIMING_SELECT_OUT(rm), .FLAG_TIMING_SELECT_OUT(flag_timing_select),
        .WEN_N_OUT(wen_n), .DATA_OUT(dq), .OFFSET_LOAD_N_OUT(ld_n),
        .SEN_N_OUT(sen_n), .SDATA_OUT(sdat), .REN_N_OUT(ren_n),
        .RETX_N_OUT(retx_n), .OE_N_OUT(oe_n), .Q_IN(q),
        .EMPTY_FLAG_N_IN(ef_n), .FULL_FLAG_N_IN(~ft),
        .ALMOST_EMPTY_FLAG_N_IN(pae_n), .ALMOST_FULL_FLAG_N_IN(1'b1),
        .HALF_FULL_FLAG_N_IN(1'b1));
    frc_dev_model u_dev (.clk_in(clk), .mrs_n_in(mrs_n), .prs_n_in(prs_n),
        .ft_in(ft), .rm_in(rm), .wen_n_in(wen_n), .d_in(dq), .ld_n_in(ld_n),
        .sen_n_in(sen_n), .sdat_in(sdat), .ren_n_in(ren_n),
        .retx_n_in(retx_n), .oe_n_in(oe_n), .q_out(q), .ef_n_out(ef_n),
        .pae_n_out(pae_n));
    task chk(input [31:0] seen, input [31:0] want);
        begin
            n_tests = n_tests + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
            end
        end
    endtask
    task close_out;
        begin
            if (num_errors == 0 && n_tests > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // a gap cycle after each strobe keeps one assignment per time step
    task wr_reg(input [3:0] a, input [31:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd_reg(input [3:0] a, input [31:0] e, input [31:0] mk);
        begin
            exp_q.push_back(e);
            msk_q.push_back(mk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(posedge clk);
        end
    endtask
    // commands need three cycles for flag sync; ten leaves margin
    task cmd(input [31:0] bits);
        begin
            wr_reg(4'h7, bits);
            repeat (10) @(posedge clk);
        end
    endtask
    // answer stands only in the cycle after the read strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0) begin
            chk(rdata & msk_q[0], exp_q[0] & msk_q[0]);
            exp_q.pop_front();
            msk_q.pop_front();
        end
    end
    // hang guard, far above the roughly 800 cycles the run needs
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            num_errors = num_errors + 1;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk({29'h0, ft, rm, flag_timing_select}, 32'h3);
        rd_reg(4'h0, 32'h1f, 32'hffffffff);
        rd_reg(4'ha, 32'h0, 32'hffffffff);
        rd_reg(4'h7, 32'h0, 32'hffffffff);
        // every pairing of timing and retransmit mode, both width modes
        for (m = 0; m < 4; m = m + 1) begin
            wr_reg(4'h0, {28'h0, m[1], !m[0], m[1], m[0]});
            cmd(32'h1);
            chk({29'h0, ft, rm, flag_timing_select}, {29'h0, m[0], m[1], !m[0]});
            rd_reg(4'h1, {27'h0, m[0], !m[0], 3'h3}, 32'h1f);
            x = m[1] ? 17 : 16;
            offs = $random(seed);
            wr_reg(4'h6, offs);
            cmd(32'h20);
            for (i = 0; i < 200 && ld_n !== 1'b1; i = i + 1)
                @(posedge clk);
            chk({25'h0, u_dev.nb_q}, 2 * (x + 1));
            for (i = 0; i < 16; i = i + 1) begin
                got[i] = u_dev.bits_q[i];
                got[i + 16] = u_dev.bits_q[i + x + 1];
            end
            chk(got, offs);
            for (i = 0; i < 3; i = i + 1)
                w[i] = $random(seed);
            wr_reg(4'h1, 32'h100);
            wr_reg(4'h2, {14'h0, w[0]});
            cmd(32'h4);
            cmd(32'h10);
            rd_reg(4'h1, 32'h100, 32'h100);
            wr_reg(4'h1, 32'h100);
            for (i = 1; i < 3; i = i + 1) begin
                wr_reg(4'h2, {14'h0, w[i]});
                cmd(32'h4);
            end
            cmd(32'h8);
            rd_reg(4'h3, {14'h0, w[0]}, 32'h3ffff);
            cmd(32'h10);
            repeat (10) @(posedge clk);
            rd_reg(4'h1, m[0] ? 32'h0 : 32'h100, 32'h100);
            if (!m[0]) begin
                cmd(32'h8);
                rd_reg(4'h3, {14'h0, w[1]}, 32'h3ffff);
                wr_reg(4'h1, 32'h100);
                cmd(32'h10);
                repeat (10) @(posedge clk);
                rd_reg(4'h1, 32'h0, 32'h100);
            end
            cmd(32'h8);
            rd_reg(4'h3, {14'h0, w[0]}, 32'h3ffff);
        end
        repeat (4) @(posedge clk);
        close_out;
    end
endmodule // frc_host_tb_top
